// File: common/capwin_params.svh
// offsets, field positions, reset values and constants of the capture window register bank
`ifndef CAPWIN_PARAMS_SVH
`define CAPWIN_PARAMS_SVH
`define CFG_LGI_OFFSET     6'h3c
`define CFG_BAR_OFFSET     6'h10
`define APP_HWIN_OFFSET    12'h000
`define APP_VWIN_OFFSET    12'h004
`define APP_CTRL_OFFSET    12'h008
`define LGI_MAX_LAT        8'h10
`define LGI_MIN_GNT        8'h02
`define LGI_INT_PIN        8'h01
`define LGI_LINE_RESET     8'h0a
`define WIN_EDGE_BIT       30
`define WIN_FIRST_MSB      19
`define WIN_FIRST_LSB      10
`define WIN_LAST_MSB       9
`define WIN_LAST_LSB       0
`define WIN_FIRST_RESET    10'h001
`define WIN_LAST_RESET     10'h3ff
`define WIN_RW_MASK        32'h400f_ffff
`define CTRL_CAPEN_BIT     0
`define CTRL_SNAP_BIT      1
`define CTRL_GRAB_BIT      2
`define CTRL_CODRD_BIT     3
`define CTRL_CRESET_BIT    4
`define CTRL_RW_MASK       32'h0000_001f
`define CTRL_RESET         32'h0000_0010
`define BAR_RW_MASK        32'hffff_f000
`endif

// File: common/capwin_pkg.sv
// types shared by the capture window register bank
package capwin_pkg;
  typedef logic [31:0] word_t;
  typedef logic [9:0]  offset_t;
endpackage : capwin_pkg

// File: rtl/capwin_edge_counter.sv
// sync edge detector and position counter for one axis
`timescale 1ns/1ps
`default_nettype none
module capwin_edge_counter
  import capwin_pkg::*;
#(
  parameter int WIDTH = 10
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_sync,
  input  wire logic             i_falling,
  input  wire logic             i_step,
  output logic                  o_edge,
  output logic [WIDTH-1:0]      o_count
);
  logic [2:0]       sync_reg;
  logic [2:0]       sync_next;
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             edge_hit;

  // ----------------------------------------------------------------
  // synchroniser, then edge pick on stages two and three only
  // ----------------------------------------------------------------
  always_comb begin
    sync_next = {sync_reg[1:0], i_sync};
    edge_hit  = i_falling ? (sync_reg[2] & ~sync_reg[1]) : (~sync_reg[2] & sync_reg[1]);
    count_next = count_reg;
    if (edge_hit) begin
      count_next = '0;
    end else if (i_step && count_reg != '1) begin
      // saturate so a missing sync never wraps back into the window
      count_next = count_reg + WIDTH'(1);
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sync_reg  <= '0;
      count_reg <= '0;
    end else begin
      sync_reg  <= sync_next;
      count_reg <= count_next;
    end
  end

  assign o_edge  = edge_hit;
  assign o_count = count_reg;
endmodule : capwin_edge_counter
`default_nettype wire

// File: rtl/capwin_regs.sv
// capture window register bank with configuration words and pixel window gate
`timescale 1ns/1ps
`default_nettype none
`include "capwin_params.svh"
module capwin_regs
  import capwin_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  input  wire logic        i_soft_rst,
  input  wire logic        i_cfg_sel,
  input  wire logic        i_mem_en,
  input  wire logic        i_req,
  input  wire logic        i_write,
  input  wire logic [31:0] i_addr,
  input  wire logic [3:0]  i_byte_en,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_hsync,
  input  wire logic        i_vsync,
  input  wire logic        i_pixel_valid,
  output logic             o_ack,
  output logic [31:0]      o_rdata,
  output logic             o_pixel_accept,
  output logic             o_capture_enable,
  output logic             o_compress_reset
);
  word_t      hwin_reg;
  word_t      hwin_next;
  word_t      vwin_reg;
  word_t      vwin_next;
  word_t      ctrl_reg;
  word_t      ctrl_next;
  word_t      bar_reg;
  word_t      bar_next;
  logic [7:0] line_reg;
  logic [7:0] line_next;
  logic       ack_reg;
  logic       ack_next;
  word_t      rdata_reg;
  word_t      rdata_next;
  logic       accept_reg;
  logic       accept_next;
  word_t      bmask;
  word_t      rd_word;
  logic       cfg_hit;
  logic       mem_hit;
  logic [11:0] app_off;
  logic       hedge;
  logic       vedge;
  offset_t    hcount;
  offset_t    vcount;
  logic       in_h;
  logic       in_v;

  // ----------------------------------------------------------------
  // position counters
  // ----------------------------------------------------------------
  capwin_edge_counter #(.WIDTH(10)) u_hcnt (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_sync    (i_hsync),
    .i_falling (hwin_reg[`WIN_EDGE_BIT]),
    .i_step    (i_pixel_valid),
    .o_edge    (hedge),
    .o_count   (hcount)
  );

  capwin_edge_counter #(.WIDTH(10)) u_vcnt (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_sync    (i_vsync),
    .i_falling (vwin_reg[`WIN_EDGE_BIT]),
    .i_step    (hedge),
    .o_edge    (vedge),
    .o_count   (vcount)
  );

  // ----------------------------------------------------------------
  // decode and next state
  // ----------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bmask[b*8 +: 8] = {8{i_byte_en[b]}};
    end
    app_off = i_addr[11:0];
    cfg_hit = i_req && i_cfg_sel;
    // only the top 20 address bits are compared, giving a 4k window
    mem_hit = i_req && !i_cfg_sel && i_mem_en
              && (i_addr[31:12] == bar_reg[31:12]);
    in_h = (hcount >= hwin_reg[`WIN_FIRST_MSB:`WIN_FIRST_LSB])
           && (hcount <= hwin_reg[`WIN_LAST_MSB:`WIN_LAST_LSB]);
    in_v = (vcount >= vwin_reg[`WIN_FIRST_MSB:`WIN_FIRST_LSB])
           && (vcount <= vwin_reg[`WIN_LAST_MSB:`WIN_LAST_LSB]);
    rd_word = '0;
    if (cfg_hit) begin
      unique case (i_addr[5:0])
        `CFG_LGI_OFFSET: rd_word = {`LGI_MAX_LAT, `LGI_MIN_GNT, `LGI_INT_PIN, line_reg};
        `CFG_BAR_OFFSET: rd_word = bar_reg;
        default:         rd_word = '0;
      endcase
    end else if (mem_hit) begin
      unique case (app_off)
        `APP_HWIN_OFFSET: rd_word = hwin_reg & `WIN_RW_MASK;
        `APP_VWIN_OFFSET: rd_word = vwin_reg & `WIN_RW_MASK;
        `APP_CTRL_OFFSET: rd_word = ctrl_reg & `CTRL_RW_MASK;
        default:          rd_word = '0;
      endcase
    end
    hwin_next = hwin_reg;
    vwin_next = vwin_reg;
    ctrl_next = ctrl_reg;
    bar_next  = bar_reg;
    line_next = line_reg;
    if (i_write && cfg_hit) begin
      if (i_addr[5:0] == `CFG_LGI_OFFSET && i_byte_en[0]) begin
        line_next = i_wdata[7:0];
      end
      if (i_addr[5:0] == `CFG_BAR_OFFSET) begin
        bar_next = ((bar_reg & ~bmask) | (i_wdata & bmask)) & `BAR_RW_MASK;
      end
    end
    if (i_write && mem_hit) begin
      // window fields are trusted to change only while capture is idle
      unique case (app_off)
        `APP_HWIN_OFFSET: hwin_next = ((hwin_reg & ~bmask) | (i_wdata & bmask)) & `WIN_RW_MASK;
        `APP_VWIN_OFFSET: vwin_next = ((vwin_reg & ~bmask) | (i_wdata & bmask)) & `WIN_RW_MASK;
        `APP_CTRL_OFFSET: ctrl_next = ((ctrl_reg & ~bmask) | (i_wdata & bmask)) & `CTRL_RW_MASK;
        default: ;
      endcase
    end
    if (i_soft_rst) begin
      ctrl_next = `CTRL_RESET;
      line_next = `LGI_LINE_RESET;
      hwin_next = {2'b00, 10'h000, `WIN_FIRST_RESET, `WIN_LAST_RESET};
      vwin_next = {2'b00, 10'h000, `WIN_FIRST_RESET, `WIN_LAST_RESET};
    end
    ack_next    = cfg_hit || mem_hit;
    rdata_next  = (!i_write) ? rd_word : '0;
    accept_next = i_pixel_valid && ctrl_reg[`CTRL_CAPEN_BIT] && in_h && in_v;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      hwin_reg   <= {2'b00, 10'h000, `WIN_FIRST_RESET, `WIN_LAST_RESET};
      vwin_reg   <= {2'b00, 10'h000, `WIN_FIRST_RESET, `WIN_LAST_RESET};
      ctrl_reg   <= `CTRL_RESET;
      bar_reg    <= '0;
      line_reg   <= `LGI_LINE_RESET;
      ack_reg    <= 1'b0;
      rdata_reg  <= '0;
      accept_reg <= 1'b0;
    end else begin
      hwin_reg   <= hwin_next;
      vwin_reg   <= vwin_next;
      ctrl_reg   <= ctrl_next;
      bar_reg    <= bar_next;
      line_reg   <= line_next;
      ack_reg    <= ack_next;
      rdata_reg  <= rdata_next;
      accept_reg <= accept_next;
    end
  end

  assign o_ack            = ack_reg;
  assign o_rdata          = rdata_reg;
  assign o_pixel_accept   = accept_reg;
  assign o_capture_enable = ctrl_reg[`CTRL_CAPEN_BIT];
  assign o_compress_reset = ctrl_reg[`CTRL_CRESET_BIT];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_cfg_consts: assert property (@(posedge i_clock) disable iff (i_rst)
    (cfg_hit && !i_write && i_addr[5:0] == 6'h3c) |=> o_ack && o_rdata[31:8] == 24'h100201)
    else $error("latency grant pin bytes wrong");
  chk_min_grant: assert property (@(posedge i_clock) disable iff (i_rst)
    (cfg_hit && !i_write && i_addr[5:0] == 6'h3c) |=> o_rdata[23:16] == 8'h02)
    else $error("min grant byte wrong");
  chk_int_pin: assert property (@(posedge i_clock) disable iff (i_rst)
    (cfg_hit && !i_write && i_addr[5:0] == 6'h3c) |=> o_rdata[15:8] == 8'h01)
    else $error("interrupt pin byte wrong");
  chk_line_write: assert property (@(posedge i_clock) disable iff (i_rst)
    (cfg_hit && i_write && i_addr[5:0] == 6'h3c && i_byte_en[0] && !i_soft_rst)
    |=> line_reg == $past(i_wdata[7:0]))
    else $error("interrupt line not stored");
  chk_window_claim: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req && !i_cfg_sel && i_mem_en && i_addr[31:12] == bar_reg[31:12]) |=> o_ack)
    else $error("window access not acknowledged");
  chk_outside_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_req && !i_cfg_sel && (!i_mem_en || i_addr[31:12] != bar_reg[31:12])) |=> !o_ack)
    else $error("access outside window acknowledged");
  chk_hole_zero: assert property (@(posedge i_clock) disable iff (i_rst)
    (mem_hit && !i_write && app_off > 12'h008) |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_byte_keep: assert property (@(posedge i_clock) disable iff (i_rst)
    (mem_hit && i_write && app_off == 12'h000 && !i_byte_en[1] && !i_soft_rst)
    |=> hwin_reg[15:8] == $past(hwin_reg[15:8]))
    else $error("disabled byte lane changed");
  chk_soft_reset: assert property (@(posedge i_clock) disable iff (i_rst)
    i_soft_rst |=> !o_capture_enable && o_compress_reset && !ctrl_reg[`CTRL_CODRD_BIT])
    else $error("soft reset state wrong");
  chk_accept_gate: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_pixel_valid && ctrl_reg[`CTRL_CAPEN_BIT]
     && hcount >= hwin_reg[`WIN_FIRST_MSB:`WIN_FIRST_LSB] && hcount <= hwin_reg[`WIN_LAST_MSB:`WIN_LAST_LSB]
     && vcount >= vwin_reg[`WIN_FIRST_MSB:`WIN_FIRST_LSB] && vcount <= vwin_reg[`WIN_LAST_MSB:`WIN_LAST_LSB])
    |=> o_pixel_accept)
    else $error("pixel inside window dropped");
  chk_pixel_window: assert property (@(posedge i_clock) disable iff (i_rst)
    o_pixel_accept |-> $past(in_h && in_v && ctrl_reg[`CTRL_CAPEN_BIT] && i_pixel_valid))
    else $error("pixel accepted outside window");
endmodule : capwin_regs
`default_nettype wire

// File: testbench/capwin_video_src.sv
// video source model: sync pulses and pixel ticks for one frame
`timescale 1ns/1ps
`default_nettype none
module capwin_video_src #(
  parameter int LINES = 3,
  parameter int TICKS = 7
) (
  input  wire logic i_clock,
  input  wire logic i_go,
  input  wire logic i_invert,
  output logic      o_hsync,
  output logic      o_vsync,
  output var logic  o_pixel_valid
);
  logic hs = 1'h0;
  logic vs = 1'h0;
  assign o_hsync = hs ^ i_invert;
  assign o_vsync = vs ^ i_invert;
  initial o_pixel_valid = 1'h0;
  // long pulses: counting from the wrong edge loses lines and pixels
  always @(posedge i_go) begin
    vs = 1'h1;
    repeat (6) @(negedge i_clock);
    for (int l = 0; l < LINES; l++) begin
      hs = 1'h1;
      repeat (6) @(negedge i_clock);
      for (int t = 1; t <= TICKS; t++) begin
        o_pixel_valid = 1'h1;
        @(negedge i_clock);
        o_pixel_valid = 1'h0;
        @(negedge i_clock);
        if (t == 4) begin
          hs = 1'h0;
          vs = (l == LINES - 1) ? 1'h0 : vs;
          repeat (6) @(negedge i_clock);
        end
      end
    end
  end
endmodule : capwin_video_src
`default_nettype wire

// File: testbench/tb_capwin_regs.sv
// self-checking bench for the capture window register bank
`timescale 1ns/1ps
`default_nettype none
module tb_capwin_regs import capwin_pkg::*;;
  typedef struct packed {logic cfg; logic wr; word_t addr; logic [3:0] be; word_t wd; logic ack; word_t rd;} row_s;
  logic       i_clock = 1'h0;
  logic       i_rst = 1'h1;
  logic       i_soft_rst = 1'h0;
  logic       i_cfg_sel = 1'h0;
  logic       i_mem_en = 1'h0;
  logic       i_req = 1'h0;
  logic       i_write = 1'h0;
  word_t      i_addr = '0;
  logic [3:0] i_byte_en = '0;
  word_t      i_wdata = '0;
  logic       go = 1'h0;
  logic       invert = 1'h0;
  logic       hsync, vsync, pixel_valid, o_ack, o_pixel_accept, o_capture_enable, o_compress_reset, ack;
  word_t      o_rdata, rd;
  int         n_fail = 0;
  int         n_tests = 0;
  int         n_acc = 0;
  word_t      hw [3] = '{32'h0000_0805, 32'h4000_0805, 32'h4000_0805};
  word_t      vw [3] = '{32'h0000_0402, 32'h4000_0402, 32'h4000_0402};
  logic       inv [3] = '{1'h0, 1'h1, 1'h1};
  word_t      en [3] = '{32'h1, 32'h1, 32'h0};
  word_t      exp_acc [3] = '{32'h8, 32'h8, 32'h0};
  // ----------------------------------------
  // register rows
  // ----------------------------------------
  row_s rows [15] = '{
    '{1'h1, 1'h0, 32'h3c, 4'hf, 32'h0, 1'h1, 32'h1002_010a},
    '{1'h1, 1'h1, 32'h3c, 4'hf, 32'hffff_ff55, 1'h1, 32'h0},
    '{1'h1, 1'h0, 32'h3c, 4'hf, 32'h0, 1'h1, 32'h1002_0155},
    '{1'h1, 1'h1, 32'h10, 4'hf, 32'h8000_0abc, 1'h1, 32'h0},
    '{1'h1, 1'h0, 32'h10, 4'hf, 32'h0, 1'h1, 32'h8000_0000},
    '{1'h0, 1'h0, 32'h8000_0000, 4'hf, 32'h0, 1'h1, 32'h0000_07ff},
    '{1'h0, 1'h0, 32'h8000_0004, 4'hf, 32'h0, 1'h1, 32'h0000_07ff},
    '{1'h0, 1'h0, 32'h8000_0008, 4'hf, 32'h0, 1'h1, 32'h0000_0010},
    '{1'h0, 1'h0, 32'h8000_0ffc, 4'hf, 32'h0, 1'h1, 32'h0},
    '{1'h0, 1'h0, 32'h8000_1000, 4'hf, 32'h0, 1'h0, 32'h0},
    '{1'h0, 1'h1, 32'h8000_0000, 4'h1, 32'h1234_5600, 1'h1, 32'h0},
    '{1'h0, 1'h1, 32'h8000_0000, 4'hc, 32'hffff_ffff, 1'h1, 32'h0},
    '{1'h0, 1'h0, 32'h8000_0000, 4'hf, 32'h0, 1'h1, 32'h400f_0700},
    '{1'h0, 1'h1, 32'h8000_0004, 4'h2, 32'hffff_ffff, 1'h1, 32'h0},
    '{1'h0, 1'h0, 32'h8000_0004, 4'hf, 32'h0, 1'h1, 32'h0000_ffff}};
  always #20 i_clock = ~i_clock;
  capwin_regs DUT (.i_clock(i_clock), .i_rst(i_rst), .i_soft_rst(i_soft_rst), .i_cfg_sel(i_cfg_sel),
    .i_mem_en(i_mem_en), .i_req(i_req), .i_write(i_write), .i_addr(i_addr), .i_byte_en(i_byte_en),
    .i_wdata(i_wdata), .i_hsync(hsync), .i_vsync(vsync), .i_pixel_valid(pixel_valid), .o_ack(o_ack),
    .o_rdata(o_rdata), .o_pixel_accept(o_pixel_accept), .o_capture_enable(o_capture_enable),
    .o_compress_reset(o_compress_reset));
  capwin_video_src u_src (.i_clock(i_clock), .i_go(go), .i_invert(invert), .o_hsync(hsync), .o_vsync(vsync),
    .o_pixel_valid(pixel_valid));
  always @(posedge i_clock) if (o_pixel_accept === 1'h1) n_acc++;
  task automatic check_val(input string what, input word_t exp, input word_t got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic bus(input logic cfg, input logic wr, input word_t addr, input logic [3:0] be, input word_t wd);
    @(negedge i_clock);
    i_cfg_sel = cfg;
    i_write = wr;
    i_addr = addr;
    i_byte_en = be;
    i_wdata = wd;
    i_req = 1'h1;
    @(negedge i_clock);
    i_req = 1'h0;
    ack = o_ack;
    rd = o_rdata;
  endtask : bus
  task automatic final_report();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (3000) @(posedge i_clock);
    n_fail++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge i_clock);
    check_val("enable in reset", 32'h0, 32'(o_capture_enable));
    check_val("compress in reset", 32'h1, 32'(o_compress_reset));
    i_rst = 1'h0;
    i_mem_en = 1'h1;
    foreach (rows[k]) begin
      bus(rows[k].cfg, rows[k].wr, rows[k].addr, rows[k].be, rows[k].wd);
      check_val($sformatf("ack %0d", k), 32'(rows[k].ack), 32'(ack));
      if (rows[k].ack) check_val($sformatf("data %0d", k), rows[k].rd, rd);
    end
    i_mem_en = 1'h0;
    bus(1'h0, 1'h0, 32'h8000_0000, 4'hf, 32'h0);
    check_val("ack memory off", 32'h0, 32'(ack));
    i_mem_en = 1'h1;
    bus(1'h0, 1'h1, 32'h8000_0008, 4'hf, 32'h0000_000f);
    @(negedge i_clock);
    check_val("enable set", 32'h1, 32'(o_capture_enable));
    check_val("compress cleared", 32'h0, 32'(o_compress_reset));
    i_soft_rst = 1'h1;
    @(negedge i_clock);
    i_soft_rst = 1'h0;
    check_val("enable soft", 32'h0, 32'(o_capture_enable));
    check_val("compress soft", 32'h1, 32'(o_compress_reset));
    bus(1'h1, 1'h0, 32'h3c, 4'hf, 32'h0);
    check_val("line soft", 32'h1002_010a, rd);
    bus(1'h0, 1'h0, 32'h8000_0008, 4'hf, 32'h0);
    check_val("ctrl soft", 32'h0000_0010, rd);
    bus(1'h0, 1'h0, 32'h8000_0000, 4'hf, 32'h0);
    check_val("hwin soft", 32'h0000_07ff, rd);
    // window only rewritten with capture off, as the host must
    for (int p = 0; p < 3; p++) begin
      bus(1'h0, 1'h1, 32'h8000_0008, 4'hf, 32'h0);
      invert = inv[p];
      bus(1'h0, 1'h1, 32'h8000_0000, 4'hf, hw[p]);
      bus(1'h0, 1'h1, 32'h8000_0004, 4'hf, vw[p]);
      bus(1'h0, 1'h1, 32'h8000_0008, 4'hf, en[p]);
      repeat (8) @(negedge i_clock);
      n_acc = 0;
      go = 1'h1;
      @(negedge i_clock);
      go = 1'h0;
      repeat (100) @(negedge i_clock);
      check_val($sformatf("accepted %0d", p), exp_acc[p], 32'(n_acc));
    end
    // hard reset in mid-run with control bits 0 to 3 set and compress reset clear
    bus(1'h0, 1'h1, 32'h8000_0008, 4'hf, 32'h0000_000f);
    i_rst = 1'h1;
    @(negedge i_clock);
    check_val("enable hard", 32'h0, 32'(o_capture_enable));
    check_val("compress hard", 32'h1, 32'(o_compress_reset));
    i_rst = 1'h0;
    bus(1'h0, 1'h0, 32'h0000_0008, 4'hf, 32'h0);
    check_val("ctrl hard", 32'h0000_0010, rd);
    final_report();
  end
endmodule : tb_capwin_regs
`default_nettype wire
